// ==== verilog/csi_pkg.sv ====
// Purpose: Shared constants and carrier types for the core status and
//          interrupt sequencing block.
// Assumes: AXI4-Lite register access, 32-bit data, word-aligned registers.
// Notes:   Register offsets are word indices; byte address is index * 4.
package csi_pkg;

  // ----------------------------------------------------------------
  // Register map (word indices)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [9:0]  IDX_PTR_HIGH  = 10'h083;
  localparam logic [9:0]  IDX_STATUS_WD = 10'h0d0;
  localparam logic [9:0]  IDX_PRIMARY   = 10'h0e0;
  localparam logic [9:0]  IDX_SECONDARY = 10'h0f0;
  localparam logic [9:0]  IDX_IRQ_EN    = 10'h100;
  localparam logic [9:0]  IDX_IRQ_PRIO  = 10'h101;
  localparam logic [9:0]  IDX_IRQ_PEND  = 10'h102;
  localparam logic [9:0]  IDX_IRQ_STAT  = 10'h103;

  // Status word bit positions, and the global enable bit of the interrupt enable word
  localparam int BIT_CARRY  = 7;
  localparam int BIT_HALF   = 6;
  localparam int BIT_USER0  = 5;
  localparam int BIT_BANK_H = 4;
  localparam int BIT_BANK_L = 3;
  localparam int BIT_RANGE  = 2;
  localparam int BIT_USER1  = 1;
  localparam int BIT_PARITY = 0;
  localparam int BIT_GLOBAL = 31;

  // Reset values and sources
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam int          NUM_SRC       = 20;
  localparam logic [19:0] RST_SRC       = 20'h00000;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam logic [15:0] VEC_STEP      = 16'h0008;
  localparam logic [4:0]  BANK_SIZE_LOG = 5'h03;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Arithmetic operations requested by the sequencer
  typedef enum logic [2:0] {
    OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV
  } csi_alu_op_t;

  typedef struct packed {
    logic        valid;
    csi_alu_op_t op;
    logic [7:0]  operand;
  } csi_alu_req_t;

  // Sequencer status toward the interrupt logic
  typedef struct packed {
    logic instrDone;    // Pulse: current instruction completes
    logic nextSingle;   // Level: following instruction is single-cycle
    logic retiDone;     // Pulse: return-from-handler completes
    logic globalClear;  // Pulse: instruction clears the global enable
  } csi_seq_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } csi_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } csi_axi_rsp_t;

endpackage : csi_pkg

// ==== verilog/csi_core_status_irq.sv ====
// Purpose: Core status byte, operand registers and interrupt sequencing.
// Assumes: One 40 MHz clock; sequencer strobes are on the same clock.
// Notes:   Operation
`timescale 1ns/100ps

module csi_core_status_irq
  import csi_pkg::*;
#(
  parameter logic [19:0] HW_CLEAR_MASK = 20'h0000f  // Auto-cleared sources
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Register bus
  input  wire csi_axi_req_t axiReq,
  output csi_axi_rsp_t      axiRsp,
  // Sequencer and arithmetic unit
  input  wire csi_seq_t     seq,
  input  wire csi_alu_req_t aluReq,
  input  wire logic [7:0]   pointerLowByte,
  // Peripheral event pulses
  input  wire logic [19:0]  srcEvent,
  // Core status outputs
  output logic [15:0]       dataPointer16,
  output logic [4:0]        bankBase,
  output logic [7:0]        primaryOperand,
  output logic [7:0]        secondaryOperand,
  // Vector request toward the sequencer
  output logic              vectorCall,
  output logic [15:0]       vectorAddr,
  output logic [4:0]        vectorSrc
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  ptrHigh_q, psw_q, acc_q, sec_q;
  logic [7:0]  psw_d, acc_d, sec_d;
  logic [19:0] enable_q, prio_q, pend_q, pend_d;
  logic        global_q, globalLate_q, skipOne_q;
  logic        actLow_q, actHigh_q;
  logic [15:0] vecAddr_q;
  logic [4:0]  vecSrc_q;
  logic        vecCall_q;

  // Bus channel state
  logic        awHeld_q, wHeld_q, bValid_q, rValid_q;
  logic [9:0]  wIdx_q;
  logic [31:0] wData_q, rData_q;
  logic [3:0]  wStrb_q;
  logic [1:0]  bResp_q, rResp_q;
  logic        wrFire;
  logic [31:0] rdMux;
  logic        rdHit;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is held until
  // both are present, and a new write waits for the response to drain.
  assign axiRsp.awready = !awHeld_q && !bValid_q;
  assign axiRsp.wready  = !wHeld_q && !bValid_q;
  assign axiRsp.bvalid  = bValid_q;
  assign axiRsp.bresp   = bResp_q;
  assign axiRsp.arready = !rValid_q;
  assign axiRsp.rvalid  = rValid_q;
  assign axiRsp.rdata   = rData_q;
  assign axiRsp.rresp   = rResp_q;
  assign wrFire         = awHeld_q && wHeld_q;

  // Write address and data capture
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      wIdx_q   <= 10'h000;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
    end else begin
      if (axiReq.awvalid && axiRsp.awready) begin
        awHeld_q <= 1'b1;
        wIdx_q   <= axiReq.awaddr[ADDR_W-1:2];
      end else if (wrFire) begin
        awHeld_q <= 1'b0;
      end
      if (axiReq.wvalid && axiRsp.wready) begin
        wHeld_q <= 1'b1;
        wData_q <= axiReq.wdata;
        wStrb_q <= axiReq.wstrb;
      end else if (wrFire) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped indices answer with a slave error
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
    end else if (wrFire) begin
      bValid_q <= 1'b1;
      bResp_q  <= (wIdx_q == IDX_PTR_HIGH || wIdx_q == IDX_STATUS_WD ||
                   wIdx_q == IDX_PRIMARY  || wIdx_q == IDX_SECONDARY ||
                   wIdx_q == IDX_IRQ_EN   || wIdx_q == IDX_IRQ_PRIO  ||
                   wIdx_q == IDX_IRQ_PEND) ? RESP_OKAY : RESP_SLVERR;
    end else if (axiReq.bready) begin
      bValid_q <= 1'b0;
    end
  end

  // Apply byte strobes to a 32-bit register image
  function automatic logic [31:0] csi_merge(input logic [31:0] old,
                                            input logic [31:0] val,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction : csi_merge

  // Strobe-merged images of the 20-bit interrupt registers
  logic [31:0] enMerge, prMerge, pdMerge;
  assign enMerge = csi_merge({12'h000, enable_q}, wData_q, wStrb_q);
  assign prMerge = csi_merge({12'h000, prio_q}, wData_q, wStrb_q);
  assign pdMerge = csi_merge({12'h000, pend_q}, wData_q, wStrb_q);

  // Read data selection
  always_comb begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case (axiReq.araddr[ADDR_W-1:2])
      IDX_PTR_HIGH:  rdMux[7:0]  = ptrHigh_q;
      IDX_STATUS_WD: rdMux[7:0]  = {psw_q[7:1], ^acc_q};
      IDX_PRIMARY:   rdMux[7:0]  = acc_q;
      IDX_SECONDARY: rdMux[7:0]  = sec_q;
      IDX_IRQ_EN:    rdMux       = {global_q, 11'h000, enable_q};
      IDX_IRQ_PRIO:  rdMux[19:0] = prio_q;
      IDX_IRQ_PEND:  rdMux[19:0] = pend_q;
      IDX_IRQ_STAT:  rdMux[6:0]  = {actHigh_q, actLow_q, vecSrc_q};
      default:       rdHit       = 1'b0;
    endcase
  end

  // Read response, one cycle after the address is taken
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= RESP_OKAY;
    end else if (axiReq.arvalid && !rValid_q) begin
      rValid_q <= 1'b1;
      rData_q  <= rdMux;
      rResp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (axiReq.rready) begin
      rValid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic flags and operand registers
  // ----------------------------------------------------------------
  // Next values of status and operands; a bus write in the same cycle
  // lands after the arithmetic update, so software has the last word.
  always_comb begin
    logic [8:0]  wide;
    logic [4:0]  nib;
    logic [15:0] prod;
    logic        cin;
    wide  = 9'h000;
    nib   = 5'h00;
    prod  = 16'h0000;
    cin   = (aluReq.op == OP_ADD) ? 1'b0 : psw_q[BIT_CARRY];
    psw_d = psw_q;
    acc_d = acc_q;
    sec_d = sec_q;
    if (aluReq.valid) begin
      case (aluReq.op)
        OP_ADD, OP_ADDC: begin
          wide = {1'b0, acc_q} + {1'b0, aluReq.operand} + {8'h00, cin};
          nib  = {1'b0, acc_q[3:0]} + {1'b0, aluReq.operand[3:0]} +
                 {4'h0, cin};
          acc_d = wide[7:0];
          psw_d[BIT_CARRY] = wide[8];
          psw_d[BIT_HALF]  = nib[4];
          psw_d[BIT_RANGE] = (acc_q[7] == aluReq.operand[7]) &&
                             (wide[7] != acc_q[7]);
        end
        OP_SUBB: begin
          wide = {1'b0, acc_q} - {1'b0, aluReq.operand} - {8'h00, cin};
          nib  = {1'b0, acc_q[3:0]} - {1'b0, aluReq.operand[3:0]} -
                 {4'h0, cin};
          acc_d = wide[7:0];
          psw_d[BIT_CARRY] = wide[8];
          psw_d[BIT_HALF]  = nib[4];
          psw_d[BIT_RANGE] = (acc_q[7] != aluReq.operand[7]) &&
                             (wide[7] != acc_q[7]);
        end
        OP_MUL: begin
          prod  = {8'h00, acc_q} * {8'h00, sec_q};
          acc_d = prod[7:0];
          sec_d = prod[15:8];
          psw_d[BIT_CARRY] = 1'b0;
          psw_d[BIT_HALF]  = 1'b0;
          psw_d[BIT_RANGE] = |prod[15:8];
        end
        OP_DIV: begin
          psw_d[BIT_CARRY] = 1'b0;
          psw_d[BIT_HALF]  = 1'b0;
          psw_d[BIT_RANGE] = (sec_q == 8'h00);
          if (sec_q != 8'h00) begin
            acc_d = acc_q / sec_q;
            sec_d = acc_q % sec_q;
          end
        end
        default: ;
      endcase
    end
    // User flags and bank bits change only by software writes
    if (wrFire && wIdx_q == IDX_STATUS_WD && wStrb_q[0]) begin
      psw_d = wData_q[7:0];
    end
    if (wrFire && wIdx_q == IDX_PRIMARY && wStrb_q[0]) begin
      acc_d = wData_q[7:0];
    end
    if (wrFire && wIdx_q == IDX_SECONDARY && wStrb_q[0]) begin
      sec_d = wData_q[7:0];
    end
  end

  // Operand and status registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      psw_q     <= RST_BYTE;
      acc_q     <= RST_BYTE;
      sec_q     <= RST_BYTE;
      ptrHigh_q <= RST_BYTE;
    end else begin
      psw_q <= psw_d;
      acc_q <= acc_d;
      sec_q <= sec_d;
      if (wrFire && wIdx_q == IDX_PTR_HIGH && wStrb_q[0]) begin
        ptrHigh_q <= wData_q[7:0];
      end
    end
  end

  assign dataPointer16    = {ptrHigh_q, pointerLowByte};
  assign bankBase         = {psw_q[BIT_BANK_H:BIT_BANK_L],
                             BANK_SIZE_LOG[2:0]} & 5'h18;
  assign primaryOperand   = acc_q;
  assign secondaryOperand = sec_q;

  // ----------------------------------------------------------------
  // Interrupt enables and priorities
  // ----------------------------------------------------------------
  // A global clear is remembered for one instruction so that a
  // single-cycle follower can still be interrupted.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      enable_q     <= RST_SRC;
      prio_q       <= RST_SRC;
      global_q     <= 1'b0;
      globalLate_q <= 1'b0;
    end else begin
      if (wrFire && wIdx_q == IDX_IRQ_EN) begin
        enable_q <= enMerge[NUM_SRC-1:0];
      end
      // A write without the top strobe must not mask a sequencer clear
      if (wrFire && wIdx_q == IDX_IRQ_EN && wStrb_q[3]) begin
        global_q <= wData_q[BIT_GLOBAL];
      end else if (seq.globalClear) begin
        global_q <= 1'b0;
      end
      if (wrFire && wIdx_q == IDX_IRQ_PRIO) begin
        prio_q <= prMerge[NUM_SRC-1:0];
      end
      if (seq.globalClear) begin
        globalLate_q <= global_q;
      end else if (seq.instrDone) begin
        globalLate_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic        globalEff;
  logic [19:0] armed;
  logic        winFound;
  logic        winHigh;
  logic [4:0]  winIdx;

  // Late clear only counts when a single-cycle instruction follows
  assign globalEff = global_q ||
                     (globalLate_q && seq.nextSingle);
  assign armed     = pend_q & enable_q &
                     {NUM_SRC{globalEff}};

  // High level first, then lowest index; preemption limited by level
  always_comb begin
    winFound = 1'b0;
    winHigh  = 1'b0;
    winIdx   = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (armed[i] && prio_q[i] && !actHigh_q) begin
        winFound = 1'b1;
        winHigh  = 1'b1;
        winIdx   = 5'(i);
      end
    end
    if (!winFound) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (armed[i] && !prio_q[i] && !actHigh_q && !actLow_q) begin
          winFound = 1'b1;
          winIdx   = 5'(i);
        end
      end
    end
  end

  logic take;
  // Vector at an instruction boundary, never on the return itself nor
  // on the single instruction that must run after it.
  assign take = winFound && seq.instrDone && !seq.retiDone &&
                !skipOne_q;

  // ----------------------------------------------------------------
  // Pending flags and handler state
  // ----------------------------------------------------------------
  // Software writes replace the flags; hardware events OR in last so a
  // set arriving with a clear is never lost.
  always_comb begin
    pend_d = pend_q;
    if (wrFire && wIdx_q == IDX_IRQ_PEND) begin
      pend_d = pdMerge[NUM_SRC-1:0];
    end
    if (take) begin
      pend_d = pend_d & ~(HW_CLEAR_MASK &
               (20'h00001 << winIdx));
    end
    pend_d = pend_d | srcEvent;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= RST_SRC;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Active handler levels; a return retires the most urgent level
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      actLow_q  <= 1'b0;
      actHigh_q <= 1'b0;
      skipOne_q <= 1'b0;
    end else begin
      if (seq.retiDone) begin
        if (actHigh_q) begin
          actHigh_q <= 1'b0;
        end else begin
          actLow_q <= 1'b0;
        end
        skipOne_q <= 1'b1;
      end else if (seq.instrDone) begin
        skipOne_q <= 1'b0;
      end
      if (take && winHigh) begin
        actHigh_q <= 1'b1;
      end else if (take) begin
        actLow_q <= 1'b1;
      end
    end
  end

  // Vector request pulse with address held until the next vector
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      vecCall_q <= 1'b0;
      vecAddr_q <= 16'h0000;
      vecSrc_q  <= 5'h00;
    end else begin
      vecCall_q <= take;
      if (take) begin
        vecSrc_q  <= winIdx;
        vecAddr_q <= VEC_BASE + VEC_STEP * {11'h000, winIdx};
      end
    end
  end

  assign vectorCall = vecCall_q;
  assign vectorAddr = vecAddr_q;
  assign vectorSrc  = vecSrc_q;

endmodule : csi_core_status_irq

// ==== bench/csi_status_checker.sv ====
// Purpose: Port-level checks for the core status and interrupt block.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/100ps
module csi_status_checker
  import csi_pkg::*;
(
  // Clock and reset
  input wire logic         clock,
  input wire logic         sys_rst,
  // Requests into the block
  input wire csi_axi_req_t axiReq,
  input wire csi_seq_t     seq,
  input wire logic [7:0]   pointerLowByte,
  // Answers from the block
  input wire csi_axi_rsp_t axiRsp,
  input wire logic [15:0]  dataPointer16,
  input wire logic [4:0]   bankBase,
  input wire logic         vectorCall,
  input wire logic [15:0]  vectorAddr,
  input wire logic [4:0]   vectorSrc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  ptr_low_a: assert property (
    dataPointer16[7:0] == pointerLowByte) else $error("pointer low byte");
  bank_base_a: assert property (
    bankBase[2:0] == 3'h0) else $error("bank base misaligned");
  // A vector may only follow a plain instruction boundary
  vec_cause_a: assert property (
    vectorCall |-> $past(seq.instrDone) && !$past(seq.retiDone))
    else $error("vector without boundary");
  vec_held_a: assert property (
    !vectorCall |-> $stable(vectorAddr) && $stable(vectorSrc))
    else $error("vector target moved");
  vec_addr_a: assert property (
    vectorCall |-> vectorAddr == VEC_BASE + {8'h00, vectorSrc, 3'h0})
    else $error("vector address");
  vec_src_a: assert property (
    vectorCall |-> vectorSrc < 5'h14) else $error("vector source range");
  rd_lat_a: assert property (
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  wr_lat_a: assert property (
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
    |-> ##2 axiRsp.bvalid) else $error("write answer late");
  rd_once_a: assert property (
    axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
    else $error("read answer repeated");
endmodule : csi_status_checker

bind csi_core_status_irq csi_status_checker u_chk (
  .clock(clock), .sys_rst(sys_rst), .axiReq(axiReq), .seq(seq),
  .pointerLowByte(pointerLowByte), .axiRsp(axiRsp),
  .dataPointer16(dataPointer16), .bankBase(bankBase),
  .vectorCall(vectorCall), .vectorAddr(vectorAddr), .vectorSrc(vectorSrc));

// ==== bench/csi_seq_model.sv ====
// Purpose: Instruction sequencer and peripheral event source model.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   gap slows the core down between instruction boundaries.
`timescale 1ns/100ps
module csi_seq_model
  import csi_pkg::*;
(
  // Clock and reset
  input wire logic   clock,
  input wire logic   sys_rst,
  // Toward the block
  output csi_seq_t    seq,
  output logic [19:0] srcEvent
);
  int gap = 0;
  // Quiet at time zero so no boundary is seen in reset
  initial begin
    seq = '0;
    srcEvent = '0;
  end
  // Leading edge wait keeps two calls from driving one step twice
  task automatic instr(input int n);
    @(posedge clock);
    for (int i = 0; i < n; i++) begin
      seq.instrDone <= 1'b1;
      @(posedge clock);
      if (gap > 0) begin
        seq.instrDone <= 1'b0;
        repeat (gap) @(posedge clock);
      end
    end
    seq.instrDone <= 1'b0;
  endtask : instr
  // Handler end, as software must write it
  task automatic return_from_handler_op();
    seq.retiDone <= 1'b1;
    @(posedge clock);
    seq.retiDone <= 1'b0;
  endtask : return_from_handler_op
  task automatic fire(input int idx);
    srcEvent[idx] <= 1'b1;
    @(posedge clock);
    srcEvent <= '0;
  endtask : fire
  // single low models the two-byte follower software should use
  task automatic clrGlobal(input logic single);
    seq.nextSingle <= single;
    seq.globalClear <= 1'b1;
    @(posedge clock);
    seq.globalClear <= 1'b0;
  endtask : clrGlobal
endmodule : csi_seq_model

// ==== bench/csi_tb.sv ====
// Purpose: Self-checking bench for the core status and interrupt block.
// Assumes: 40 MHz clock, AXI4-Lite master with ready lines held high.
// Notes:   Expected values are worked out by hand from the flag rules.
`timescale 1ns/100ps
module tb;
  import csi_pkg::*;
  logic         clock = 1'b0;
  logic         sys_rst = 1'b1;
  csi_axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
  csi_axi_rsp_t rsp;
  csi_seq_t     seq;
  csi_alu_req_t alu = '0;
  logic [7:0]   ptrLow = 8'h00;
  logic [7:0]   pOut, sOut;
  logic [19:0]  srcEvent;
  logic [15:0]  dp, vAddr;
  logic [4:0]   bank, vSrc;
  logic         vCall;
  logic [31:0]  rd;
  logic [1:0]   resp;
  logic [9:0]   regIdx [4] = '{IDX_PTR_HIGH, IDX_STATUS_WD, IDX_PRIMARY,
                               IDX_SECONDARY};
  int           fails = 0, checks = 0, vecN = 0, v0;

  csi_core_status_irq DUT (
    .clock(clock), .sys_rst(sys_rst), .axiReq(req), .axiRsp(rsp),
    .seq(seq), .aluReq(alu), .pointerLowByte(ptrLow), .srcEvent(srcEvent),
    .dataPointer16(dp), .bankBase(bank), .primaryOperand(pOut),
    .secondaryOperand(sOut), .vectorCall(vCall), .vectorAddr(vAddr),
    .vectorSrc(vSrc));
  csi_seq_model SEQ (.clock(clock), .sys_rst(sys_rst), .seq(seq),
    .srcEvent(srcEvent));

  always #12.5 clock = ~clock;
  // Count vector pulses; target is read straight from the held outputs
  always @(posedge clock) if (vCall === 1'b1) vecN <= vecN + 1;

  task automatic conclude();
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] x, g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // ------------------------------------------------------------
  // Bus tasks: handshakes judged at the falling edge, moved at rising
  // ------------------------------------------------------------
  task automatic axWrite(input logic [9:0] idx, input logic [31:0] d,
                         input logic [3:0] s = 4'hf);
    logic aw, w, b, ta, tw;
    int n;
    aw = 1; w = 1; b = 0; n = 0;
    req.awvalid <= 1'b1; req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1; req.wdata <= d; req.wstrb <= s;
    while (!b && n < 40) begin
      @(negedge clock);
      ta = aw && rsp.awready === 1'b1;
      tw = w && rsp.wready === 1'b1;
      b = rsp.bvalid === 1'b1;
      resp = rsp.bresp;
      @(posedge clock);
      if (ta) begin req.awvalid <= 1'b0; aw = 0; end
      if (tw) begin req.wvalid <= 1'b0; w = 0; end
      n++;
    end
    if (!b) chk("write answer", 32'h1, 32'h0);
  endtask : axWrite
  task automatic axRead(input logic [9:0] idx);
    logic ar, got, ta;
    int n;
    ar = 1; got = 0; n = 0;
    req.arvalid <= 1'b1; req.araddr <= {idx, 2'b00};
    while (!got && n < 40) begin
      @(negedge clock);
      ta = ar && rsp.arready === 1'b1;
      got = rsp.rvalid === 1'b1;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clock);
      if (ta) begin req.arvalid <= 1'b0; ar = 0; end
      n++;
    end
    if (!got) chk("read answer", 32'h1, 32'h0);
  endtask : axRead
  task automatic doAlu(input csi_alu_op_t op,
                       input logic [7:0] a, b, pIn, aX, bX, pX);
    axWrite(IDX_STATUS_WD, {24'h0, pIn});
    axWrite(IDX_PRIMARY, {24'h0, a});
    axWrite(IDX_SECONDARY, {24'h0, b});
    alu <= '{1'b1, op, b};
    @(posedge clock);
    alu.valid <= 1'b0;
    axRead(IDX_PRIMARY);
    chk("result", {24'h0, aX}, rd);
    chk("acc out", {24'h0, aX}, {24'h0, pOut});
    axRead(IDX_SECONDARY);
    chk("second", {24'h0, bX}, rd);
    chk("second out", {24'h0, bX}, {24'h0, sOut});
    axRead(IDX_STATUS_WD);
    chk("flags", {24'h0, pX}, rd);
  endtask : doAlu
  task automatic run(input int n);
    SEQ.instr(n);
    repeat (3) @(posedge clock);
  endtask : run
  task automatic vecChk(input int k, input logic [15:0] a);
    chk("vectors", v0 + k, vecN);
    chk("target", {16'h0, a}, {16'h0, vAddr});
  endtask : vecChk
  task automatic doReset();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    v0 = vecN;
  endtask : doReset

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      axRead(regIdx[i]);
      chk("reset value", {24'h0, RST_BYTE}, rd);
    end
    axRead(10'h050);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axWrite(IDX_IRQ_STAT, 32'h1);
    chk("ro", {30'h0, RESP_SLVERR}, {30'h0, resp});
    ptrLow <= 8'h3c;
    axWrite(IDX_PTR_HIGH, 32'ha5);
    chk("pointer", 32'ha53c, {16'h0, dp});
    // Byte lane 0 off: an 8-bit register must keep its value
    axWrite(IDX_PTR_HIGH, 32'h5a, 4'he);
    chk("strobe", 32'ha53c, {16'h0, dp});
    for (int b = 0; b < 4; b++) begin
      axWrite(IDX_STATUS_WD, b << 3);
      chk("bank", b * 8, {27'h0, bank});
    end
    // Flag presets differ so that clearing shows as well as setting
    doAlu(OP_ADD, 8'h7f, 8'h01, 8'hc4, 8'h80, 8'h01, 8'h45);
    doAlu(OP_ADD, 8'h12, 8'h34, 8'he6, 8'h46, 8'h34, 8'h23);
    doAlu(OP_ADD, 8'hff, 8'h01, 8'h00, 8'h00, 8'h01, 8'hc0);
    doAlu(OP_ADDC, 8'h0e, 8'h01, 8'h80, 8'h10, 8'h01, 8'h41);
    doAlu(OP_SUBB, 8'h00, 8'h01, 8'h80, 8'hfe, 8'h01, 8'hc1);
    doAlu(OP_MUL, 8'h10, 8'h10, 8'hc4, 8'h00, 8'h01, 8'h04);
    doAlu(OP_DIV, 8'h55, 8'h00, 8'hc4, 8'h55, 8'h00, 8'h04);
    doAlu(OP_DIV, 8'h64, 8'h0a, 8'hc4, 8'h0a, 8'h00, 8'h00);
    // Interrupts, first on a slow core
    v0 = vecN;
    SEQ.gap = 2;
    axWrite(IDX_IRQ_EN, 32'h20);
    SEQ.fire(5);
    axRead(IDX_IRQ_PEND); chk("pending", 32'h20, rd);
    run(2); vecChk(0, 16'h0);
    axWrite(IDX_IRQ_EN, 32'h80000000);
    run(2); vecChk(0, 16'h0);
    SEQ.gap = 0;
    axWrite(IDX_IRQ_EN, 32'h80000020);
    run(1); vecChk(1, 16'h002b);
    axRead(IDX_IRQ_PEND); chk("kept", 32'h20, rd);
    SEQ.return_from_handler_op();
    run(1); vecChk(1, 16'h002b);
    run(1); vecChk(2, 16'h002b);
    axWrite(IDX_IRQ_PEND, 32'h0);
    SEQ.return_from_handler_op();
    run(2); vecChk(2, 16'h002b);
    axWrite(IDX_IRQ_EN, 32'h80000008);
    SEQ.fire(3);
    run(1); vecChk(3, 16'h001b);
    axRead(IDX_IRQ_PEND); chk("auto clear", 32'h0, rd);
    SEQ.return_from_handler_op();
    axWrite(IDX_IRQ_PRIO, 32'h201);
    axWrite(IDX_IRQ_EN, 32'h80000205);
    axWrite(IDX_IRQ_PEND, 32'h204);
    run(2); vecChk(4, 16'h004b);
    run(2); vecChk(4, 16'h004b);
    axWrite(IDX_IRQ_PEND, 32'h4);
    SEQ.return_from_handler_op();
    run(2); vecChk(5, 16'h0013);
    axWrite(IDX_IRQ_PEND, 32'h1);
    run(1); vecChk(6, 16'h0003);
    // Late global clear, single-cycle then multi-cycle follower
    doReset();
    axWrite(IDX_IRQ_EN, 32'h80000002);
    SEQ.clrGlobal(1'b1);
    SEQ.fire(1);
    run(1); vecChk(1, 16'h000b);
    axRead(IDX_IRQ_EN); chk("global", 32'h2, rd);
    doReset();
    axRead(IDX_PRIMARY); chk("reset again", 32'h0, rd);
    axWrite(IDX_IRQ_EN, 32'h80000002);
    SEQ.clrGlobal(1'b0);
    SEQ.fire(1);
    run(1); vecChk(0, 16'h0);
    conclude();
  end
endmodule : tb
